// file: hdl/pbc_regs.svh
/*
  Register offsets, field positions, implemented-bit masks and reset values
  for the port B / port C pin-function selector.
  Assumes it is included by bare name into design units that need them.
*/
`ifndef PBC_REGS_SVH
`define PBC_REGS_SVH

// Summary of operation
// - Full variant: pin B7 code {select bit 7, pin-7 extra bit}: 00 I/O, 01 analog 2, 10 inverted timer 1, 11 serial transmit.
// - Full variant: pin B6 code {select bit 6, pin-6 extra bit}: 00 I/O, 01 analog 1, 10 timer 1, 11 serial receive.
// - Full variant: pin B5 code {pin-5 extra bit, select bit 5}: 00 I/O, 01 inverted timer 0, 10 ADC reference out, 11 analog 0.
// - Full variant: pin B4 code {pin-4 extra bit, select bit 4}: 00 and 11 I/O, 01 timer 0, 10 ADC reference in.
// - Full variant: select bits 3..2 equal to 11 give pins B3/B2 to the low-speed crystal, else both stay I/O.
// - Full variant: select bits 1..0 equal to 11 give pins B1/B0 to the main oscillator, else both stay I/O.
// - Reduced variant: port B select bits 7..4 ignore writes and read as zero.
// - Reduced and mid variants: pins B3/B2 go to the low-speed crystal only for field value 11.
// - Reduced and mid variants: pins B1/B0 go to the main oscillator only for field value 11.
// - Mid variant: select bit 5 alone picks I/O (0) or inverted timer 0 (1) for pin B5.
// - Mid variant: select bit 4 alone picks I/O (0) or timer 0 (1) for pin B4.
// - Full variant: port C select bits 6..3 route pins C6..C3 to analog 11, 10, 9, 8 when one, else I/O.
// - Port C select bit 7 and bits 2..0 ignore writes and read as zero.
// - Full variant: the secondary register holds extra bits pin 4 at bit 4, pin 5 at 3, pin 7 at 2, pin 6 at 1.

// ==========================================================================
// Register byte offsets
`define PBC_OFS_PORT_B 12'h000
`define PBC_OFS_PORT_C 12'h004
`define PBC_OFS_SECONDARY 12'h008

// ==========================================================================
// Implemented-bit masks per variant
`define PBC_PB_MASK_FULL 8'hFF
`define PBC_PB_MASK_REDUCED 8'h0F
`define PBC_PB_MASK_MID 8'hFF
`define PBC_PC_MASK_FULL 8'h78
`define PBC_PC_MASK_OTHER 8'h00
`define PBC_SEC_MASK_FULL 8'h1E
`define PBC_SEC_MASK_OTHER 8'h00

// ==========================================================================
// Secondary register field positions, port C low field bit and reset value
`define PBC_SEC_PIN4_BIT 4
`define PBC_SEC_PIN5_BIT 3
`define PBC_SEC_PIN7_BIT 2
`define PBC_SEC_PIN6_BIT 1
`define PBC_PC_LOW_BIT 3
`define PBC_RESET_VALUE 8'h00

`endif

// file: hdl/pbc_pkg.sv
/*
  Types for the port B / port C pin-function selector: device variant and
  per-pin function codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pbc_pkg;

  // ========================================================================
  // Device variant chosen at build time
  typedef enum logic [1:0] {
    variant_full,
    variant_reduced,
    variant_mid
  } pbc_variant_e;

  // ========================================================================
  // Function chosen for one port B pin
  typedef enum logic [3:0] {
    func_gpio,
    func_analog,
    func_timer0_out,
    func_timer0_inv,
    func_timer1_out,
    func_timer1_inv,
    func_uart_tx,
    func_uart_rx,
    func_adc_ref_out,
    func_adc_ref_in,
    func_low_speed_crystal,
    func_main_oscillator
  } pbc_func_e;

endpackage

// file: hdl/pbc_decode.sv
/*
  Combinational decode of stored select bits into per-pin functions.
  Assumes the select inputs are already masked to the implemented bits.
*/
`timescale 1ns/100ps
`include "pbc_regs.svh"

module pbc_decode #(
  parameter pbc_pkg::pbc_variant_e VARIANT = pbc_pkg::variant_full
) (
  input wire logic [7:0] pb_sel,
  input wire logic [7:0] sec_sel,
  input wire logic [7:0] pc_sel,
  output pbc_pkg::pbc_func_e pb_func [8],
  output logic [3:0] pc_analog
);

  logic [1:0] code7;
  logic [1:0] code6;
  logic [1:0] code5;
  logic [1:0] code4;

  // ========================================================================
  // Two-bit codes; note pins 5 and 4 put the extra bit on top
  assign code7 = {pb_sel[7], sec_sel[`PBC_SEC_PIN7_BIT]};
  assign code6 = {pb_sel[6], sec_sel[`PBC_SEC_PIN6_BIT]};
  assign code5 = {sec_sel[`PBC_SEC_PIN5_BIT], pb_sel[5]};
  assign code4 = {sec_sel[`PBC_SEC_PIN4_BIT], pb_sel[4]};

  // Upper port B pins depend on the variant
  always_comb begin
    pb_func[7] = pbc_pkg::func_gpio;
    pb_func[6] = pbc_pkg::func_gpio;
    pb_func[5] = pbc_pkg::func_gpio;
    pb_func[4] = pbc_pkg::func_gpio;
    case (VARIANT)
      pbc_pkg::variant_full: begin
        case (code7)
          2'h1: pb_func[7] = pbc_pkg::func_analog;
          2'h2: pb_func[7] = pbc_pkg::func_timer1_inv;
          2'h3: pb_func[7] = pbc_pkg::func_uart_tx;
          default: pb_func[7] = pbc_pkg::func_gpio;
        endcase
        case (code6)
          2'h1: pb_func[6] = pbc_pkg::func_analog;
          2'h2: pb_func[6] = pbc_pkg::func_timer1_out;
          2'h3: pb_func[6] = pbc_pkg::func_uart_rx;
          default: pb_func[6] = pbc_pkg::func_gpio;
        endcase
        case (code5)
          2'h1: pb_func[5] = pbc_pkg::func_timer0_inv;
          2'h2: pb_func[5] = pbc_pkg::func_adc_ref_out;
          2'h3: pb_func[5] = pbc_pkg::func_analog;
          default: pb_func[5] = pbc_pkg::func_gpio;
        endcase
        case (code4)
          2'h1: pb_func[4] = pbc_pkg::func_timer0_out;
          2'h2: pb_func[4] = pbc_pkg::func_adc_ref_in;
          default: pb_func[4] = pbc_pkg::func_gpio;
        endcase
      end
      pbc_pkg::variant_mid: begin
        if (pb_sel[7]) begin
          pb_func[7] = pbc_pkg::func_timer1_inv;
        end
        if (pb_sel[6]) begin
          pb_func[6] = pbc_pkg::func_timer1_out;
        end
        if (pb_sel[5]) begin
          pb_func[5] = pbc_pkg::func_timer0_inv;
        end
        if (pb_sel[4]) begin
          pb_func[4] = pbc_pkg::func_timer0_out;
        end
      end
      default: begin
        pb_func[7] = pbc_pkg::func_gpio;
      end
    endcase
  end

  // Crystal and oscillator pairs only take the all-ones value
  always_comb begin
    pb_func[3] = pbc_pkg::func_gpio;
    pb_func[2] = pbc_pkg::func_gpio;
    pb_func[1] = pbc_pkg::func_gpio;
    pb_func[0] = pbc_pkg::func_gpio;
    if (pb_sel[3:2] == 2'h3) begin
      pb_func[3] = pbc_pkg::func_low_speed_crystal;
      pb_func[2] = pbc_pkg::func_low_speed_crystal;
    end
    if (pb_sel[1:0] == 2'h3) begin
      pb_func[1] = pbc_pkg::func_main_oscillator;
      pb_func[0] = pbc_pkg::func_main_oscillator;
    end
  end

  // Port C analog routing, one bit per pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pc
      assign pc_analog[gi] = (VARIANT == pbc_pkg::variant_full)
                             && pc_sel[`PBC_PC_LOW_BIT + gi];
    end
  endgenerate

endmodule

// file: hdl/pbc_pin_select.sv
/*
  Port B / port C pin-function selector: three APB-mapped select registers
  and the per-pin function outputs that steer the pad multiplexers.
  Assumes an APB master on the same clock, byte lane 0 carrying the data,
  and pad logic that consumes the decoded enables.
*/
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "pbc_regs.svh"

module pbc_pin_select #(
  parameter pbc_pkg::pbc_variant_e VARIANT = pbc_pkg::variant_full
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] port_b_pin_func,
  output logic [7:0] port_b_gpio,
  output logic [3:0] port_c_gpio,
  output logic [11:0] analog_channel_en,
  output logic timer0_output_en,
  output logic timer0_inverted_output_en,
  output logic timer1_output_en,
  output logic timer1_inverted_output_en,
  output logic uart_tx_en,
  output logic uart_rx_en,
  output logic adc_reference_output_en,
  output logic adc_reference_input_en,
  output logic low_speed_crystal_pins_en,
  output logic main_oscillator_pins_en
);

  // ========================================================================
  // Implemented-bit masks, fixed by the variant
  localparam logic [7:0] PB_MASK = (VARIANT == pbc_pkg::variant_full) ? `PBC_PB_MASK_FULL :
                                   (VARIANT == pbc_pkg::variant_mid) ? `PBC_PB_MASK_MID :
                                   `PBC_PB_MASK_REDUCED;
  localparam logic [7:0] PC_MASK = (VARIANT == pbc_pkg::variant_full) ? `PBC_PC_MASK_FULL :
                                   `PBC_PC_MASK_OTHER;
  localparam logic [7:0] SEC_MASK = (VARIANT == pbc_pkg::variant_full) ? `PBC_SEC_MASK_FULL :
                                    `PBC_SEC_MASK_OTHER;

  logic [7:0] port_b_function_select_reg;
  logic [7:0] port_c_function_select_reg;
  logic [7:0] secondary_select_register_reg;
  logic [7:0] port_b_function_select_next;
  logic [7:0] port_c_function_select_next;
  logic [7:0] secondary_select_register_next;
  logic wr_en;
  logic rd_en;
  logic hit_b;
  logic hit_c;
  logic hit_sec;
  logic hit_any;
  logic lane0;
  logic [31:0] prdata_next;
  pbc_pkg::pbc_func_e pb_func [8];
  logic [3:0] pc_analog;

  // ========================================================================
  // APB decode; the slave never inserts wait states
  assign pready = 1'b1;
  assign hit_b = (paddr == `PBC_OFS_PORT_B);
  assign hit_c = (paddr == `PBC_OFS_PORT_C);
  assign hit_sec = (paddr == `PBC_OFS_SECONDARY);
  assign hit_any = hit_b | hit_c | hit_sec;
  assign lane0 = pstrb[0];
  assign wr_en = psel & penable & pwrite & hit_any & lane0;
  assign rd_en = psel & ~penable & ~pwrite;
  // Unmapped access gets an error in its access phase, nothing is stored
  assign pslverr = psel & penable & ~hit_any;

  // ========================================================================
  // Next values: only implemented bits take a write, the rest stay zero
  always_comb begin
    port_b_function_select_next = port_b_function_select_reg;
    port_c_function_select_next = port_c_function_select_reg;
    secondary_select_register_next = secondary_select_register_reg;
    if (wr_en && hit_b) begin
      port_b_function_select_next = pwdata[7:0] & PB_MASK;
    end
    if (wr_en && hit_c) begin
      port_c_function_select_next = pwdata[7:0] & PC_MASK;
    end
    if (wr_en && hit_sec) begin
      secondary_select_register_next = pwdata[7:0] & SEC_MASK;
    end
  end

  // Port B select register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_b_function_select_reg <= `PBC_RESET_VALUE;
    end else begin
      port_b_function_select_reg <= port_b_function_select_next;
    end
  end

  // Port C select register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_c_function_select_reg <= `PBC_RESET_VALUE;
    end else begin
      port_c_function_select_reg <= port_c_function_select_next;
    end
  end

  // Secondary select register with the extra port B bits
  always_ff @(posedge clk) begin
    if (!resetn) begin
      secondary_select_register_reg <= `PBC_RESET_VALUE;
    end else begin
      secondary_select_register_reg <= secondary_select_register_next;
    end
  end

  // ========================================================================
  // Read data is captured in the setup phase so it is a flop in the access
  // phase; the registers cannot change between the two phases of a read
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (hit_b) begin
      prdata_next = {24'h00_0000, port_b_function_select_reg};
    end else if (hit_c) begin
      prdata_next = {24'h00_0000, port_c_function_select_reg};
    end else if (hit_sec) begin
      prdata_next = {24'h00_0000, secondary_select_register_reg};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= prdata_next;
    end
  end

  // ========================================================================
  // Per-pin decode from the stored bits, no extra latency
  pbc_decode #(
    .VARIANT(VARIANT)
  ) u_decode (
    .pb_sel(port_b_function_select_reg),
    .sec_sel(secondary_select_register_reg),
    .pc_sel(port_c_function_select_reg),
    .pb_func(pb_func),
    .pc_analog(pc_analog)
  );

  // ========================================================================
  // Pack pin functions and general I/O flags, one slice per pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pb
      assign port_b_pin_func[4*gi +: 4] = pb_func[gi];
      assign port_b_gpio[gi] = (pb_func[gi] == pbc_pkg::func_gpio);
    end
  endgenerate

  assign port_c_gpio = ~pc_analog;

  // Analog channel map: B6/B7 feed channels 1/2, B5 channel 0, C3..C6 8..11
  assign analog_channel_en[0] = (pb_func[5] == pbc_pkg::func_analog);
  assign analog_channel_en[1] = (pb_func[6] == pbc_pkg::func_analog);
  assign analog_channel_en[2] = (pb_func[7] == pbc_pkg::func_analog);
  assign analog_channel_en[7:3] = 5'h00;
  assign analog_channel_en[11:8] = pc_analog;

  // ========================================================================
  // Peripheral routing strobes for the pad and peripheral side
  assign timer0_output_en = (pb_func[4] == pbc_pkg::func_timer0_out);
  assign timer0_inverted_output_en = (pb_func[5] == pbc_pkg::func_timer0_inv);
  assign timer1_output_en = (pb_func[6] == pbc_pkg::func_timer1_out);
  assign timer1_inverted_output_en = (pb_func[7] == pbc_pkg::func_timer1_inv);
  assign uart_tx_en = (pb_func[7] == pbc_pkg::func_uart_tx);
  assign uart_rx_en = (pb_func[6] == pbc_pkg::func_uart_rx);
  assign adc_reference_output_en = (pb_func[5] == pbc_pkg::func_adc_ref_out);
  assign adc_reference_input_en = (pb_func[4] == pbc_pkg::func_adc_ref_in);
  // Both pins of a pair switch together, so one flag per pair suffices
  assign low_speed_crystal_pins_en = (pb_func[3] == pbc_pkg::func_low_speed_crystal);
  assign main_oscillator_pins_en = (pb_func[1] == pbc_pkg::func_main_oscillator);

endmodule

// file: tb/pbc_pin_select_props.sv
/*
  Concurrent checks for the port B / port C pin-function selector, every variant.
  Assumes it is bound onto pbc_pin_select and sees one clock domain.
*/
`timescale 1ns/100ps

module pbc_pin_select_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] port_b_gpio,
  input wire logic [3:0] port_c_gpio,
  input wire logic [11:0] analog_channel_en,
  input wire logic timer0_output_en,
  input wire logic timer0_inverted_output_en,
  input wire logic timer1_output_en,
  input wire logic timer1_inverted_output_en,
  input wire logic uart_tx_en,
  input wire logic uart_rx_en,
  input wire logic adc_reference_output_en,
  input wire logic adc_reference_input_en,
  input wire logic low_speed_crystal_pins_en,
  input wire logic main_oscillator_pins_en
);
  // ==========================================================================
  // Bus sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence strb_off_s;
    psel && penable && pwrite && !pstrb[0];
  endsequence
  sequence osc_write_s;
    psel && penable && pwrite && pstrb[0] && paddr == 12'h000 && pwdata[1:0] == 2'b11;
  endsequence

  // ==========================================================================
  // Properties; reset check ignores the default disable so it can see the reset
  reset_clears_a: assert property (disable iff (1'b0) !resetn |=>
    port_b_gpio == 8'hFF && port_c_gpio == 4'hF && prdata == 32'h0)
    else $error("reset did not clear selector");
  slave_ready_a: assert property (psel |-> pready) else $error("pready low");
  decode_error_a: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008})) else $error("pslverr wrong");
  masked_write_a: assert property (strb_off_s |=> $stable(port_b_gpio))
    else $error("masked write changed pins");
  osc_write_a: assert property (osc_write_s |=> main_oscillator_pins_en)
    else $error("oscillator select not applied");
  crystal_pins_a: assert property (port_b_gpio[3:2] == {2{!low_speed_crystal_pins_en}})
    else $error("crystal pins mismatch");
  osc_pins_a: assert property (port_b_gpio[1:0] == {2{!main_oscillator_pins_en}})
    else $error("oscillator pins mismatch");
  pin7_choice_a: assert property ($onehot({port_b_gpio[7], uart_tx_en,
    timer1_inverted_output_en, analog_channel_en[2]})) else $error("pin 7 not exclusive");
  pin6_choice_a: assert property ($onehot({port_b_gpio[6], uart_rx_en,
    timer1_output_en, analog_channel_en[1]})) else $error("pin 6 not exclusive");
  pin5_choice_a: assert property ($onehot({port_b_gpio[5], adc_reference_output_en,
    timer0_inverted_output_en, analog_channel_en[0]})) else $error("pin 5 not exclusive");
  pin4_choice_a: assert property ($onehot({port_b_gpio[4], timer0_output_en,
    adc_reference_input_en})) else $error("pin 4 not exclusive");
  port_c_analog_a: assert property (port_c_gpio == ~analog_channel_en[11:8] &&
    analog_channel_en[7:3] == 5'h00) else $error("port C analog mismatch");
  read_upper_zero_a: assert property (prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
endmodule

bind pbc_pin_select pbc_pin_select_props pbc_pin_select_props_inst (.clk, .resetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .port_b_gpio,
  .port_c_gpio, .analog_channel_en, .timer0_output_en, .timer0_inverted_output_en,
  .timer1_output_en, .timer1_inverted_output_en, .uart_tx_en, .uart_rx_en,
  .adc_reference_output_en, .adc_reference_input_en, .low_speed_crystal_pins_en,
  .main_oscillator_pins_en);

// file: tb/tb_port_bc_pin_function_select.sv
/*
  Self-checking bench for the pin-function selector, full variant with mid and reduced builds alongside.
  Assumes the design answers APB within a few cycles; all waits are bounded.
*/
`timescale 1ns/100ps

module tb_port_bc_pin_function_select;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, port_b_pin_func, rd;
  logic [3:0] pstrb = 4'hF, port_c_gpio;
  logic [7:0] port_b_gpio;
  logic [11:0] analog_channel_en;
  logic timer0_output_en, timer0_inverted_output_en, timer1_output_en, err;
  logic timer1_inverted_output_en, uart_tx_en, uart_rx_en, adc_reference_output_en;
  logic adc_reference_input_en, low_speed_crystal_pins_en, main_oscillator_pins_en;
  logic [14:0] exp_v;
  logic [31:0] prdata_r;
  logic [7:0] port_b_gpio_m, port_b_gpio_r;
  logic timer0_output_en_m, timer0_inverted_output_en_m, timer1_output_en_m;
  logic timer1_inverted_output_en_m;
  int n_fail = 0, n_checks = 0;

  // ==========================================================================
  // Clock and design
  always #2 clk = ~clk;
  pbc_pin_select #(.VARIANT(pbc_pkg::variant_full)) pbc_pin_select_inst (.clk, .resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .port_b_pin_func, .port_b_gpio, .port_c_gpio, .analog_channel_en, .timer0_output_en,
    .timer0_inverted_output_en, .timer1_output_en, .timer1_inverted_output_en, .uart_tx_en,
    .uart_rx_en, .adc_reference_output_en, .adc_reference_input_en,
    .low_speed_crystal_pins_en, .main_oscillator_pins_en);
  // Mid and reduced builds share the bus, so every write reaches all three
  pbc_pin_select #(.VARIANT(pbc_pkg::variant_mid)) pbc_pin_select_mid_inst (.clk, .resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata(), .pready(), .pslverr(),
    .port_b_pin_func(), .port_b_gpio(port_b_gpio_m), .port_c_gpio(), .analog_channel_en(),
    .timer0_output_en(timer0_output_en_m),
    .timer0_inverted_output_en(timer0_inverted_output_en_m),
    .timer1_output_en(timer1_output_en_m),
    .timer1_inverted_output_en(timer1_inverted_output_en_m), .uart_tx_en(), .uart_rx_en(),
    .adc_reference_output_en(), .adc_reference_input_en(), .low_speed_crystal_pins_en(),
    .main_oscillator_pins_en());
  pbc_pin_select #(.VARIANT(pbc_pkg::variant_reduced)) pbc_pin_select_reduced_inst (.clk,
    .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata(prdata_r),
    .pready(), .pslverr(), .port_b_pin_func(), .port_b_gpio(port_b_gpio_r), .port_c_gpio(),
    .analog_channel_en(), .timer0_output_en(), .timer0_inverted_output_en(),
    .timer1_output_en(), .timer1_inverted_output_en(), .uart_tx_en(), .uart_rx_en(),
    .adc_reference_output_en(), .adc_reference_input_en(), .low_speed_crystal_pins_en(),
    .main_oscillator_pins_en());

  // ==========================================================================
  // Verdict and comparison
  task automatic results;
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // ==========================================================================
  // APB transfer; an idle edge follows so the next setup never collides
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 12; a += 4) begin
      xfer(1'b0, 12'(a), 32'h0, 4'hF);
      chk("reset read", rd, 32'h0);
    end
    chk("reset gpio", {port_b_gpio, port_c_gpio}, 12'hFFF);
    // Same two-bit code on pins 7..4 through both select registers
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 12'h000, {24'h0, c[1], c[1], c[0], c[0], 4'h0}, 4'hF);
      xfer(1'b1, 12'h008, {27'h0, c[1], c[1], c[0], c[0]} << 1, 4'hF);
      exp_v = {c == 3, c == 3, c == 2, c == 2, c == 1, c == 1, c == 2, c == 2,
               c == 1, c == 1, c == 3, c == 0, c == 0, c == 0, c == 0 || c == 3};
      chk("pins 7..4", {uart_tx_en, uart_rx_en, timer1_inverted_output_en,
        timer1_output_en, timer0_inverted_output_en, timer0_output_en, adc_reference_output_en,
        adc_reference_input_en, analog_channel_en[2:0], port_b_gpio[7:4]}, exp_v);
    end
    // Every value of the two shared low fields
    for (int v = 0; v < 16; v++) begin
      xfer(1'b1, 12'h000, 32'(v), 4'hF);
      xfer(1'b0, 12'h000, 32'h0, 4'hF);
      chk("port b read", rd, 32'(v));
      chk("crystal", low_speed_crystal_pins_en, v[3:2] == 2'b11);
      chk("oscillator", main_oscillator_pins_en, v[1:0] == 2'b11);
      chk("gpio 3..0", port_b_gpio[3:0], {{2{v[3:2] != 2'b11}}, {2{v[1:0] != 2'b11}}});
    end
    xfer(1'b1, 12'h000, 32'hFF, 4'h0);
    xfer(1'b0, 12'h000, 32'h0, 4'hF);
    chk("masked write", rd, 32'h0F);
    // Secondary still holds 1E from the code loop, so pins 7..4 take the extra-bit codes
    chk("pin functions", port_b_pin_func,
      {pbc_pkg::func_analog, pbc_pkg::func_analog, pbc_pkg::func_adc_ref_out,
       pbc_pkg::func_adc_ref_in, {2{pbc_pkg::func_low_speed_crystal}},
       {2{pbc_pkg::func_main_oscillator}}});
    xfer(1'b1, 12'h004, 32'hFFFFFFFF, 4'hF);
    xfer(1'b0, 12'h004, 32'h0, 4'hF);
    chk("port c read", rd, 32'h78);
    xfer(1'b1, 12'h004, 32'h48, 4'hF);
    chk("port c analog", {analog_channel_en[11:8], port_c_gpio}, 8'h96);
    xfer(1'b1, 12'h008, 32'hFF, 4'hF);
    xfer(1'b0, 12'h008, 32'h0, 4'hF);
    chk("secondary read", rd, 32'h1E);
    xfer(1'b1, 12'h00C, 32'hFF, 4'hF);
    chk("unmapped write err", err, 1'b1);
    xfer(1'b0, 12'h00C, 32'h0, 4'hF);
    chk("unmapped read err", err, 1'b1);
    chk("unmapped read", rd, 32'h0);
    // Mid decodes single bits on pins 7..4; reduced drops the upper nibble
    xfer(1'b1, 12'h000, 32'hF0, 4'hF);
    chk("mid pins 7..4", {timer1_inverted_output_en_m, timer1_output_en_m,
      timer0_inverted_output_en_m, timer0_output_en_m, port_b_gpio_m}, 12'hF0F);
    chk("reduced gpio", port_b_gpio_r, 8'hFF);
    xfer(1'b1, 12'h000, 32'hFF, 4'hF);
    xfer(1'b0, 12'h000, 32'h0, 4'hF);
    chk("reduced read", prdata_r, 32'h0F);
    chk("low pairs", {port_b_gpio_m[3:0], port_b_gpio_r}, 12'h0F0);
    // Second reset in mid-run
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("rereset gpio", {port_b_gpio, port_c_gpio, analog_channel_en}, 24'hFFF000);
    chk("rereset variants", {port_b_gpio_m, port_b_gpio_r}, 16'hFFFF);
    results();
  end
endmodule
